/* File: hdl/ocss_regs.vh */
`ifndef OCSS_REGS_VH
`define OCSS_REGS_VH
// ********************************************************
// Register offsets
// ********************************************************
`define OCSS_ADDR_CTRL 4'h0
`define OCSS_ADDR_TRIM 4'h1
`define OCSS_ADDR_PIN 4'h2
`define OCSS_ADDR_CFG 4'h3
// ********************************************************
// Field positions
// ********************************************************
`define OCSS_CTRL_OPT_LSB 6
`define OCSS_CTRL_INTERNAL_FREQ_SELECT_LSB 4
`define OCSS_CTRL_CRYSTAL_RANGE_SELECT_LSB 2
`define OCSS_CTRL_REQ_BIT 1
`define OCSS_CTRL_ENG_BIT 0
`define OCSS_PIN_OE_BIT 0
`define OCSS_CFG_KEEP_BIT 0
// ********************************************************
// Encodings and reset values
// ********************************************************
`define OCSS_OPT_INT 2'h0
`define OCSS_OPT_EXT 2'h1
`define OCSS_OPT_RC 2'h2
`define OCSS_OPT_XTAL 2'h3
`define OCSS_INTERNAL_FREQ_SELECT_4M 2'h0
`define OCSS_INTERNAL_FREQ_SELECT_8M 2'h1
`define OCSS_INTERNAL_FREQ_SELECT_12M8 2'h2
`define OCSS_TRIM_RST 8'h00
`define OCSS_BUS_DIV 4
`define OCSS_EDGES_NEEDED 2'h2
`endif

/* File: hdl/ocss_switch.v */
`timescale 1ns/1ps
`include "ocss_regs.vh"
// Operation
// - Bus clock runs at one quarter of whichever source is active.
// - Internal oscillator has three frequencies; lowest selected after reset.
// - Full-rate clock follows the selected source frequency.
// - Half-rate clock is full-rate halved, fed onward.
// - Stop mode disables oscillators per enable, unless keep-alive set.
// - Signed 8-bit trim steers internal period, larger means slower.
// - Configured option enables input pin; crystal also claims second pin.
// - After request, two external rising edges, then switch, engaged first.
// - Clearing option and request returns to internal source.
// - External clock mode: pin clock direct, output enable forced clear.
// - Crystal mode: second pin dedicated, output enable bit ignored.
// - Internal or RC: second pin outputs full-rate only when enabled.
// - Option field: 00 internal, 01 external, 10 RC, 11 crystal.
// - Frequency select: 00 4 MHz, 01 8 MHz, 10 12.8 MHz.
// - Request clears on reset, ignored in monitor bypass mode.
// - Engaged status reads one while external source drives clock.
module ocss_switch #(
	parameter TRIM_W = 8
) (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [3:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	input wire internal_clock_in,
	input wire rc_clock_in,
	input wire crystal_clock_in,
	input wire clock_input_pin_in,
	input wire stop_mode_in,
	input wire sys_osc_enable_in,
	input wire monitor_bypass_in,
	output reg full_rate_clock_out,
	output reg half_rate_clock_out,
	output reg bus_clock_en_out,
	output reg int_osc_run_out,
	output reg rc_osc_run_out,
	output reg xtal_osc_run_out,
	output reg [1:0] int_freq_out,
	output reg [TRIM_W-1:0] trim_setting_out,
	output reg [1:0] crystal_range_select_out,
	output reg clock_input_pin_en_out,
	output reg clock_second_pin_xtal_out,
	output reg clock_second_pin_out,
	output reg clock_second_pin_oe_out
);
	localparam ST_INT = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_EXT = 2'h2;
	localparam ST_BACK = 2'h3;

	reg [1:0] source_option_q;
	reg [1:0] internal_freq_select_q;
	reg [1:0] crystal_range_select_q;
	reg ext_clock_request_q;
	reg ext_clock_engaged_q;
	reg clk_pin_output_enable_q;
	reg osc_keepalive_in_stop_q;
	reg [TRIM_W-1:0] trim_setting_q;
	reg [1:0] state_q;
	reg [1:0] edge_cnt_q;
	reg [1:0] div_q;
	reg [2:0] src_s1_q;
	reg [2:0] src_s2_q;
	reg [2:0] src_s3_q;
	reg pin_s1_q;
	reg pin_s2_q;
	reg pin_s3_q;
	reg mon_s1_q;
	reg mon_s2_q;
	reg stop_s1_q;
	reg stop_s2_q;
	reg en_s1_q;
	reg en_s2_q;
	reg sel_clk_d;
	reg [7:0] rdata_d;
	wire req_eff;
	wire osc_off;
	wire ext_rise;

	// ********************************************************
	// Input synchronisers
	// ********************************************************
	// Oscillator clocks arrive asynchronously; sampled, not used as clocks
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			src_s1_q <= 3'h0;
			src_s2_q <= 3'h0;
			src_s3_q <= 3'h0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			mon_s1_q <= 1'b0;
			mon_s2_q <= 1'b0;
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
			en_s1_q <= 1'b1;
			en_s2_q <= 1'b1;
		end else begin
			src_s1_q <= {crystal_clock_in, rc_clock_in, internal_clock_in};
			src_s2_q <= src_s1_q;
			src_s3_q <= src_s2_q;
			pin_s1_q <= clock_input_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			mon_s1_q <= monitor_bypass_in;
			mon_s2_q <= mon_s1_q;
			stop_s1_q <= stop_mode_in;
			stop_s2_q <= stop_s1_q;
			en_s1_q <= sys_osc_enable_in;
			en_s2_q <= en_s1_q;
		end
	end

	// Request has no effect in monitor bypass mode
	assign req_eff = ext_clock_request_q & ~mon_s2_q;
	// Keep-alive bit overrides the stop-mode disable
	assign osc_off = stop_s2_q & ~en_s2_q & ~osc_keepalive_in_stop_q;
	// Edge seen on synchronised external source
	assign ext_rise = sel_ext_now(source_option_q, src_s2_q, pin_s2_q) &
		~sel_ext_now(source_option_q, src_s3_q, pin_s3_q);

	// Pick external-source sample by option code
	function sel_ext_now;
		input [1:0] opt;
		input [2:0] src;
		input pin;
		begin
			case (opt)
			`OCSS_OPT_EXT: sel_ext_now = pin;
			`OCSS_OPT_RC: sel_ext_now = src[1];
			`OCSS_OPT_XTAL: sel_ext_now = src[2];
			default: sel_ext_now = 1'b0;
			endcase
		end
	endfunction

	// ********************************************************
	// Register file
	// ********************************************************
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			source_option_q <= `OCSS_OPT_INT;
			internal_freq_select_q <= `OCSS_INTERNAL_FREQ_SELECT_4M;
			crystal_range_select_q <= 2'h0;
			ext_clock_request_q <= 1'b0;
			clk_pin_output_enable_q <= 1'b0;
			osc_keepalive_in_stop_q <= 1'b0;
			trim_setting_q <= `OCSS_TRIM_RST;
		end else if (wr_in) begin
			case (addr_in)
			`OCSS_ADDR_CTRL: begin
				source_option_q <= wdata_in[`OCSS_CTRL_OPT_LSB+:2];
				internal_freq_select_q <= wdata_in[`OCSS_CTRL_INTERNAL_FREQ_SELECT_LSB+:2];
				crystal_range_select_q <= wdata_in[`OCSS_CTRL_CRYSTAL_RANGE_SELECT_LSB+:2];
				ext_clock_request_q <= wdata_in[`OCSS_CTRL_REQ_BIT];
			end
			`OCSS_ADDR_TRIM: trim_setting_q <= wdata_in[TRIM_W-1:0];
			`OCSS_ADDR_PIN: begin
				clk_pin_output_enable_q <= wdata_in[`OCSS_PIN_OE_BIT];
			end
			`OCSS_ADDR_CFG: begin
				osc_keepalive_in_stop_q <= wdata_in[`OCSS_CFG_KEEP_BIT];
			end
			default: begin
			end
			endcase
		end
	end

	// Read mux; engaged status is read only
	always @* begin
		rdata_d = 8'h00;
		case (addr_in)
		`OCSS_ADDR_CTRL: begin
			rdata_d = {source_option_q, internal_freq_select_q,
				crystal_range_select_q, ext_clock_request_q,
				ext_clock_engaged_q};
		end
		`OCSS_ADDR_TRIM: rdata_d = trim_setting_q;
		`OCSS_ADDR_PIN: rdata_d = {7'h00, clk_pin_output_enable_q};
		`OCSS_ADDR_CFG: rdata_d = {7'h00, osc_keepalive_in_stop_q};
		default: rdata_d = 8'h00;
		endcase
	end

	// Read data valid only the cycle after the strobe
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			rdata_out <= rdata_d;
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ********************************************************
	// Switch sequencer
	// ********************************************************
	// Internal keeps running until engaged is set, so never clockless
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_INT;
			edge_cnt_q <= 2'h0;
			ext_clock_engaged_q <= 1'b0;
		end else begin
			case (state_q)
			ST_INT: begin
				edge_cnt_q <= 2'h0;
				if (req_eff && source_option_q != `OCSS_OPT_INT) begin
					state_q <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!req_eff) begin
					state_q <= ST_INT;
				end else if (ext_rise) begin
					if (edge_cnt_q == `OCSS_EDGES_NEEDED - 2'h1) begin
						ext_clock_engaged_q <= 1'b1;
						state_q <= ST_EXT;
					end
					edge_cnt_q <= edge_cnt_q + 2'h1;
				end
			end
			ST_EXT: begin
				if (!req_eff && source_option_q == `OCSS_OPT_INT) begin
					state_q <= ST_BACK;
				end
			end
			ST_BACK: begin
				// Internal restarted this cycle; release external next
				ext_clock_engaged_q <= 1'b0;
				state_q <= ST_INT;
			end
			default: state_q <= ST_INT;
			endcase
		end
	end

	// ********************************************************
	// Clock selection and dividers
	// ********************************************************
	// Source mux; engaged flag gates external selection
	always @* begin
		sel_clk_d = src_s2_q[0];
		if (ext_clock_engaged_q && state_q != ST_BACK) begin
			sel_clk_d = sel_ext_now(source_option_q, src_s2_q,
				pin_s2_q);
		end
		if (osc_off) begin
			sel_clk_d = 1'b0;
		end
	end

	// Divide chain: half rate, then bus enable at one quarter
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q <= 2'h0;
			full_rate_clock_out <= 1'b0;
			half_rate_clock_out <= 1'b0;
			bus_clock_en_out <= 1'b0;
		end else begin
			full_rate_clock_out <= sel_clk_d;
			bus_clock_en_out <= 1'b0;
			if (sel_clk_d && !full_rate_clock_out) begin
				div_q <= div_q + 2'h1;
				half_rate_clock_out <= ~half_rate_clock_out;
				bus_clock_en_out <= (div_q == `OCSS_BUS_DIV - 1);
			end
		end
	end

	// ********************************************************
	// Oscillator enables and pin control
	// ********************************************************
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			int_osc_run_out <= 1'b1;
			rc_osc_run_out <= 1'b0;
			xtal_osc_run_out <= 1'b0;
			int_freq_out <= `OCSS_INTERNAL_FREQ_SELECT_4M;
			trim_setting_out <= `OCSS_TRIM_RST;
			crystal_range_select_out <= 2'h0;
			clock_input_pin_en_out <= 1'b0;
			clock_second_pin_xtal_out <= 1'b0;
			clock_second_pin_out <= 1'b0;
			clock_second_pin_oe_out <= 1'b0;
		end else begin
			// Internal stops once engaged or on osc_off; restarts on return
			int_osc_run_out <= ~osc_off &
				(~ext_clock_engaged_q | state_q == ST_BACK);
			rc_osc_run_out <= ~osc_off &
				(source_option_q == `OCSS_OPT_RC);
			xtal_osc_run_out <= ~osc_off &
				(source_option_q == `OCSS_OPT_XTAL);
			int_freq_out <= internal_freq_select_q;
			trim_setting_out <= trim_setting_q;
			crystal_range_select_out <= crystal_range_select_q;
			clock_input_pin_en_out <=
				(source_option_q != `OCSS_OPT_INT);
			clock_second_pin_xtal_out <=
				(source_option_q == `OCSS_OPT_XTAL);
			clock_second_pin_out <= sel_clk_d;
			// External and crystal force the output enable off
			clock_second_pin_oe_out <= clk_pin_output_enable_q &
				(source_option_q == `OCSS_OPT_INT ||
				source_option_q == `OCSS_OPT_RC);
		end
	end
endmodule

/* File: test/ocss_sim_model.sv */
`timescale 1ns/1ps
// ****
// Consumer of the generated clocks
// ****
module ocss_sim_model (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire half_rate_in,
	output reg bus_clk_out
);
	reg half_q;
	// Bus clock is the half-rate clock halved once more
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			half_q <= 1'h0;
			bus_clk_out <= 1'h0;
		end else begin
			half_q <= half_rate_in;
			if (half_rate_in && !half_q)
				bus_clk_out <= ~bus_clk_out;
		end
	end
endmodule

/* File: test/ocss_switch_asserts.sv */
`timescale 1ns/1ps
module ocss_switch_chk (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire full_rate_clock_out,
	input wire half_rate_clock_out,
	input wire bus_clock_en_out,
	input wire int_osc_run_out,
	input wire clock_input_pin_en_out,
	input wire clock_second_pin_xtal_out,
	input wire clock_second_pin_out,
	input wire clock_second_pin_oe_out
);
	// ****
	// Edge helpers
	// ****
	reg f1_q;
	reg f2_q;
	reg [2:0] rises_q;
	wire rise_now = full_rate_clock_out & ~f1_q;
	wire rise_prev = f1_q & ~f2_q;
	// Rises since the last bus pulse; a pulse may lag its rise by one
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			f1_q <= 1'h0;
			f2_q <= 1'h0;
			rises_q <= 3'h0;
		end else begin
			f1_q <= full_rate_clock_out;
			f2_q <= f1_q;
			if (bus_clock_en_out)
				rises_q <= {2'h0, rise_now};
			else if (rise_now)
				rises_q <= rises_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	// ****
	// Properties
	// ****
	half_toggle_a: assert property ($changed(half_rate_clock_out) |->
		rise_now || rise_prev) else $error("half rate moved off a rise");
	bus_pulse_a: assert property (bus_clock_en_out |=>
		!bus_clock_en_out) else $error("bus pulse too long");
	bus_align_a: assert property (bus_clock_en_out |->
		rise_now || rise_prev) else $error("bus pulse off a rise");
	bus_count_a: assert property (rises_q <= 3'h4)
		else $error("more than four rises per bus pulse");
	reset_int_a: assert property ($rose(rst_n_in) |->
		int_osc_run_out) else $error("internal osc off after reset");
	pin_claim_a: assert property (clock_second_pin_xtal_out |->
		clock_input_pin_en_out) else $error("crystal without input pin");
	oe_xtal_a: assert property (clock_second_pin_oe_out |->
		!clock_second_pin_xtal_out) else $error("pin driven in crystal");
	pin_clock_a: assert property (clock_second_pin_oe_out |->
		clock_second_pin_out == full_rate_clock_out ||
		clock_second_pin_out == f1_q) else $error("pin not full rate");
	cover property (bus_clock_en_out);
	cover property (clock_second_pin_oe_out);
	cover property ($fell(int_osc_run_out));
endmodule
bind ocss_switch ocss_switch_chk u_chk (.clk_sys_in, .rst_n_in,
	.full_rate_clock_out, .half_rate_clock_out, .bus_clock_en_out,
	.int_osc_run_out, .clock_input_pin_en_out,
	.clock_second_pin_xtal_out, .clock_second_pin_out,
	.clock_second_pin_oe_out);

/* File: test/ocss_switch_tb.sv */
`timescale 1ns/1ps
`include "ocss_regs.vh"
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin \
num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, v); end end
module ocss_switch_tb;
	reg clk_sys_in, rst_n_in, wr_in, rd_in, stop, osc_en, byp, pin_run;
	reg [3:0] addr_in;
	reg [7:0] wdata_in, rv;
	reg [4:0] cyc = 5'h00;
	wire [7:0] rdata_out, trim;
	wire [1:0] freq, xtal_rng;
	wire full, half, bus_en, int_run, pin_en, xtal, pin_o, oe, sys_bus;
	wire rc_run, xtal_run;
	integer num_errors = 0, tests_run = 0, o;
	// Slow sources: internal 16 cycles, external pin 8 cycles
	always @(posedge clk_sys_in) cyc <= cyc + 5'h1;
	ocss_switch DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .internal_clock_in(cyc[3]),
		.rc_clock_in(cyc[4]), .crystal_clock_in(cyc[2]),
		.clock_input_pin_in(pin_run & cyc[2]), .stop_mode_in(stop),
		.sys_osc_enable_in(osc_en), .monitor_bypass_in(byp),
		.full_rate_clock_out(full), .half_rate_clock_out(half),
		.bus_clock_en_out(bus_en), .int_osc_run_out(int_run),
		.rc_osc_run_out(rc_run), .xtal_osc_run_out(xtal_run),
		.int_freq_out(freq), .trim_setting_out(trim),
		.crystal_range_select_out(xtal_rng),
		.clock_input_pin_en_out(pin_en), .clock_second_pin_xtal_out(xtal),
		.clock_second_pin_out(pin_o), .clock_second_pin_oe_out(oe));
	ocss_sim_model u_sim (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.half_rate_in(half), .bus_clk_out(sys_bus));
	// ****
	// Bus and measuring tasks
	// ****
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk_sys_in);
			addr_in <= a;
			wdata_in <= d;
			wr_in <= 1'h1;
			@(posedge clk_sys_in);
			wr_in <= 1'h0;
			// Copies of fields may lag the register by a cycle
			repeat (2) @(posedge clk_sys_in);
			#1;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge clk_sys_in);
			addr_in <= a;
			rd_in <= 1'h1;
			@(posedge clk_sys_in);
			rd_in <= 1'h0;
			#1 rv = rdata_out;
		end
	endtask
	// Cycles between two rises of the bus pulse or the consumer clock
	task per(input integer s, input integer e);
		integer n, k, t;
		reg p;
		begin
			n = 0;
			k = 0;
			t = 0;
			p = 1'h1;
			// Total wait is bounded even if no pulse ever comes
			while (k < 2 && t < 600) begin
				@(posedge clk_sys_in);
				#1;
				t = t + 1;
				if (k > 0) n = n + 1;
				if ((s ? sys_bus : bus_en) && !p) k = k + 1;
				p = s ? sys_bus : bus_en;
			end
			if (k < 2) n = 0;
			`CHK("period", e, n)
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", tests_run, num_errors);
			if (num_errors == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// ****
	// Scenarios
	// ****
	// Option first, settle, then request; poll until engaged
	task engage(input [1:0] opt);
		begin
			wr(`OCSS_ADDR_CTRL, {opt, 6'h00});
			// Source must settle before the request goes up
			repeat (20) @(posedge clk_sys_in);
			wr(`OCSS_ADDR_CTRL, {opt, 6'h02});
			o = 0;
			rv = 8'h00;
			while (!rv[0] && o < 60) begin
				rd(`OCSS_ADDR_CTRL);
				o++;
			end
			`CHK("engaged", {opt, 6'h03}, rv)
		end
	endtask
	task t_reset;
		begin
			rd(`OCSS_ADDR_CTRL);
			`CHK("ctrl", 8'h00, rv)
			`CHK("int_run", 1'h1, int_run)
			`CHK("freq", 2'h0, freq)
			`CHK("trim rst", 8'h00, trim)
			per(0, 64);
			per(1, 64);
			$display("test reset done");
		end
	endtask
	task t_regs;
		begin
			for (o = 0; o < 4; o++) begin
				wr(`OCSS_ADDR_CTRL, {2'h0, o[1:0], o[1:0], 2'h0});
				`CHK("freq", o[1:0], freq)
				`CHK("range", o[1:0], xtal_rng)
			end
			wr(`OCSS_ADDR_CTRL, 8'h01);
			rd(`OCSS_ADDR_CTRL);
			`CHK("eng ro", 8'h00, rv)
			// Software loads its own copy of the factory trim
			wr(`OCSS_ADDR_TRIM, 8'h80);
			`CHK("trim", 8'h80, trim)
			wr(`OCSS_ADDR_TRIM, 8'h7F);
			rd(`OCSS_ADDR_TRIM);
			`CHK("trim rd", 8'h7F, rv)
			wr(4'h9, 8'hFF);
			rd(4'h9);
			`CHK("unmapped", 8'h00, rv)
			$display("test regs done");
		end
	endtask
	task t_ext;
		begin
			wr(`OCSS_ADDR_CTRL, 8'h40);
			`CHK("pin_en", 1'h1, pin_en)
			// Pin stays quiet: request alone must not engage
			repeat (20) @(posedge clk_sys_in);
			wr(`OCSS_ADDR_CTRL, 8'h42);
			repeat (20) @(posedge clk_sys_in);
			rd(`OCSS_ADDR_CTRL);
			`CHK("quiet pin", 8'h42, rv)
			pin_run <= 1'h1;
			o = 0;
			rv = 8'h00;
			while (!rv[0] && o < 30) begin
				rd(`OCSS_ADDR_CTRL);
				o++;
			end
			`CHK("engaged", 8'h43, rv)
			repeat (4) @(posedge clk_sys_in);
			#1;
			`CHK("int_run", 1'h0, int_run)
			wr(`OCSS_ADDR_PIN, 8'h01);
			`CHK("oe", 1'h0, oe)
			per(0, 32);
			per(1, 32);
			wr(`OCSS_ADDR_CTRL, 8'h00);
			rd(`OCSS_ADDR_CTRL);
			`CHK("back", 8'h00, rv)
			`CHK("int_run", 1'h1, int_run)
			per(0, 64);
			pin_run <= 1'h0;
			$display("test switch done");
		end
	endtask
	task t_pins;
		begin
			for (o = 0; o < 4; o++) begin
				wr(`OCSS_ADDR_CTRL, {o[1:0], 6'h00});
				`CHK("pin_en", o != 0, pin_en)
				`CHK("xtal", o == 3, xtal)
				`CHK("oe", o == 0 || o == 2, oe)
				`CHK("rc_run", o == 2, rc_run)
				`CHK("xtal_run", o == 3, xtal_run)
			end
			wr(`OCSS_ADDR_CTRL, 8'h00);
			wr(`OCSS_ADDR_PIN, 8'h00);
			$display("test pins done");
		end
	endtask
	// Crystal: 8-cycle source; RC: 32-cycle source
	task t_xtal;
		begin
			engage(`OCSS_OPT_XTAL);
			wr(`OCSS_ADDR_PIN, 8'h01);
			`CHK("xtal oe", 1'h0, oe)
			`CHK("int_run", 1'h0, int_run)
			per(0, 32);
			wr(`OCSS_ADDR_CTRL, 8'h00);
			rd(`OCSS_ADDR_CTRL);
			`CHK("xtal back", 8'h00, rv)
			engage(`OCSS_OPT_RC);
			`CHK("rc oe", 1'h1, oe)
			per(0, 128);
			wr(`OCSS_ADDR_CTRL, 8'h00);
			wr(`OCSS_ADDR_PIN, 8'h00);
			rd(`OCSS_ADDR_CTRL);
			`CHK("rc back", 8'h00, rv)
			`CHK("int_run", 1'h1, int_run)
			$display("test crystal and rc done");
		end
	endtask
	task t_stop;
		begin
			stop <= 1'h1;
			osc_en <= 1'h0;
			repeat (6) @(posedge clk_sys_in);
			#1;
			`CHK("int_run", 1'h0, int_run)
			`CHK("full", 1'h0, full)
			wr(`OCSS_ADDR_CFG, 8'h01);
			`CHK("keep", 1'h1, int_run)
			per(0, 64);
			stop <= 1'h0;
			osc_en <= 1'h1;
			wr(`OCSS_ADDR_CFG, 8'h00);
			// Monitor bypass must mask the request
			byp <= 1'h1;
			pin_run <= 1'h1;
			wr(`OCSS_ADDR_CTRL, 8'h42);
			repeat (40) @(posedge clk_sys_in);
			rd(`OCSS_ADDR_CTRL);
			`CHK("bypass", 8'h42, rv)
			`CHK("int_run", 1'h1, int_run)
			$display("test stop done");
		end
	endtask
	initial begin
		clk_sys_in = 1'h0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	// Whole run is under two thousand cycles
	initial begin
		#2000000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		{rst_n_in, wr_in, rd_in, stop, byp, pin_run} = 6'h00;
		{addr_in, wdata_in} = 12'h000;
		osc_en = 1'h1;
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		t_reset;
		t_regs;
		t_ext;
		t_pins;
		t_xtal;
		t_stop;
		report_and_stop;
	end
endmodule
